// file: verilog/parallel_port_map.svh
`ifndef PARALLEL_PORT_MAP_SVH
`define PARALLEL_PORT_MAP_SVH

`define OFS_OUT_WORD_ONE 8'h00
`define OFS_OUT_WORD_TWO 8'h04
`define OFS_IN_WORD_ONE 8'h08
`define OFS_IN_WORD_TWO 8'h0c
`define OFS_PORT_STATUS 8'h10
`define OFS_PAD_CONFIG 8'h14
`define OFS_PORT_CONTROL 8'h18
`define OFS_IRQ_STATUS 8'h1c
`define OFS_IRQ_MASK 8'h20

`define BIT_IN_OVERFLOW 14
`define BIT_OUT_UNDERFLOW 6
`define BIT_SOURCE_SELECT 1
`define BIT_THRESHOLD 0
`define BIT_MASTER_MODE 0

`define IRQ_HOST_WROTE 0
`define IRQ_HOST_READ 1
`define IRQ_OVERFLOW 2
`define IRQ_UNDERFLOW 3

`define RST_OUT_EMPTY 4'hf
`define RST_IN_FULL 4'h0
`define RST_PAD_CONFIG 2'h0
`define RST_IRQ_MASK 4'h0

`endif

// file: verilog/parallel_port_pkg.sv
package parallel_port_pkg;

  typedef struct packed {
    logic csN;
    logic rdN;
    logic wrN;
    logic [1:0] addr;
    logic [7:0] data;
  } pins_type;

  typedef struct packed {
    pins_type sync1;
    pins_type sync2;
    pins_type sync3;
    pins_type pinStable;
    logic [15:0] outWordOne;
    logic [15:0] outWordTwo;
    logic [15:0] inWordOne;
    logic [15:0] inWordTwo;
    logic [3:0] outEmpty;
    logic [3:0] inFull;
    logic inOverflow;
    logic outUnderflow;
    logic [1:0] padConfig;
    logic masterMode;
    logic [3:0] irqStatus;
    logic [3:0] irqMask;
    logic [31:0] rdata;
    logic [7:0] hostDataOut;
  } state_type;

endpackage

// file: verilog/parallel_slave_port.sv
`timescale 1ns/1ns
`include "parallel_port_map.svh"

module parallel_slave_port
  import parallel_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hostCsN,
  input wire logic hostRdN,
  input wire logic hostWrN,
  input wire logic [1:0] portAddressLines,
  input wire logic [7:0] hostDataIn,
  output logic [7:0] hostDataOut,
  output logic hostDataOe,
  output logic [15:0] masterAddress,
  output logic masterMode,
  output logic portInputThresholdSelect,
  input wire logic secondsClock,
  input wire logic alarmPulse,
  input wire logic calendarPinOutputEnable,
  output logic calendarPin,
  output logic calendarPinOe,
  output logic irq
);

  state_type state_q;
  state_type state_d;
  pins_type pinsNow;
  logic hostRead;
  logic hostWrite;
  logic [1:0] rdIdx;
  logic [1:0] wrIdx;
  logic [7:0] selByte;
  logic [15:0] statusWord;
  logic apbAccess;
  logic swWrite;
  logic swRead;
  logic mapped;
  logic [7:0] wordAddr;

  assign pinsNow = '{csN: hostCsN, rdN: hostRdN, wrN: hostWrN,
                     addr: portAddressLines, data: hostDataIn};

  // host strobes once second and third stages agree
  assign hostRead = (state_q.sync2 == state_q.sync3) && !state_q.sync3.rdN &&
                    state_q.pinStable.rdN && !state_q.sync3.csN && !state_q.masterMode;
  assign hostWrite = (state_q.sync2 == state_q.sync3) && state_q.sync3.wrN &&
                     !state_q.pinStable.wrN && !state_q.pinStable.csN && !state_q.masterMode;
  assign rdIdx = state_q.sync3.addr;
  assign wrIdx = state_q.pinStable.addr;

  always_comb begin
    case (rdIdx)
      2'h0: selByte = state_q.outWordOne[7:0];
      2'h1: selByte = state_q.outWordOne[15:8];
      2'h2: selByte = state_q.outWordTwo[7:0];
      2'h3: selByte = state_q.outWordTwo[15:8];
      default: selByte = 8'h00;
    endcase
  end

  assign statusWord = {&state_q.inFull, state_q.inOverflow, 2'h0, state_q.inFull,
                       &state_q.outEmpty, state_q.outUnderflow, 2'h0,
                       state_q.outEmpty};

  assign apbAccess = psel && penable;
  assign swWrite = apbAccess && pwrite;
  assign swRead = apbAccess && !pwrite;
  assign wordAddr = {paddr[7:2], 2'h0};

  always_comb begin
    case (wordAddr)
      `OFS_OUT_WORD_ONE, `OFS_OUT_WORD_TWO, `OFS_IN_WORD_ONE, `OFS_IN_WORD_TWO,
      `OFS_PORT_STATUS, `OFS_PAD_CONFIG, `OFS_PORT_CONTROL, `OFS_IRQ_STATUS,
      `OFS_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    state_d = state_q;
    // pin synchroniser and agreement filter
    state_d.sync1 = pinsNow;
    state_d.sync2 = state_q.sync1;
    state_d.sync3 = state_q.sync2;
    if (state_q.sync2 == state_q.sync3) begin
      state_d.pinStable = state_q.sync3;
    end

    // read data captured in setup phase
    if (psel && !penable) begin
      case (wordAddr)
        `OFS_OUT_WORD_ONE: state_d.rdata = {16'h0000, state_q.outWordOne};
        `OFS_OUT_WORD_TWO: state_d.rdata = {16'h0000, state_q.outWordTwo};
        `OFS_IN_WORD_ONE: state_d.rdata = {16'h0000, state_q.inWordOne};
        `OFS_IN_WORD_TWO: state_d.rdata = {16'h0000, state_q.inWordTwo};
        `OFS_PORT_STATUS: state_d.rdata = {16'h0000, statusWord};
        `OFS_PAD_CONFIG: state_d.rdata = {30'h0, state_q.padConfig};
        `OFS_PORT_CONTROL: state_d.rdata = {31'h0, state_q.masterMode};
        `OFS_IRQ_STATUS: state_d.rdata = {28'h0, state_q.irqStatus};
        `OFS_IRQ_MASK: state_d.rdata = {28'h0, state_q.irqMask};
        default: state_d.rdata = 32'h00000000;
      endcase
    end

    // software reads of input words release their bytes
    if (swRead && wordAddr == `OFS_IN_WORD_ONE) begin
      state_d.inFull[1:0] = 2'h0;
    end
    if (swRead && wordAddr == `OFS_IN_WORD_TWO) begin
      state_d.inFull[3:2] = 2'h0;
    end

    // write-one-to-clear of sticky flags, plain writes of irq mask, pad config and control
    if (swWrite && wordAddr == `OFS_PORT_STATUS) begin
      if (pstrb[1] && pwdata[`BIT_IN_OVERFLOW]) begin
        state_d.inOverflow = 1'b0;
      end
      if (pstrb[0] && pwdata[`BIT_OUT_UNDERFLOW]) begin
        state_d.outUnderflow = 1'b0;
      end
    end
    if (swWrite && wordAddr == `OFS_IRQ_STATUS && pstrb[0]) begin
      state_d.irqStatus = state_q.irqStatus & ~pwdata[3:0];
    end
    if (swWrite && wordAddr == `OFS_IRQ_MASK && pstrb[0]) begin
      state_d.irqMask = pwdata[3:0];
    end
    if (swWrite && wordAddr == `OFS_PAD_CONFIG && pstrb[0]) begin
      state_d.padConfig = pwdata[1:0];
    end
    if (swWrite && wordAddr == `OFS_PORT_CONTROL && pstrb[0]) begin
      state_d.masterMode = pwdata[`BIT_MASTER_MODE];
    end

    // host read of an output byte
    if (hostRead) begin
      state_d.hostDataOut = selByte;
      state_d.irqStatus[`IRQ_HOST_READ] = 1'b1;
      if (state_q.outEmpty[rdIdx]) begin
        state_d.outUnderflow = 1'b1;
        state_d.irqStatus[`IRQ_UNDERFLOW] = 1'b1;
      end else begin
        state_d.outEmpty[rdIdx] = 1'b1;
      end
    end

    // host write of an input byte
    if (hostWrite) begin
      state_d.inFull[wrIdx] = 1'b1;
      state_d.irqStatus[`IRQ_HOST_WROTE] = 1'b1;
      if (state_q.inFull[wrIdx]) begin
        state_d.inOverflow = 1'b1;
        state_d.irqStatus[`IRQ_OVERFLOW] = 1'b1;
      end
      case (wrIdx)
        2'h0: state_d.inWordOne[7:0] = state_q.pinStable.data;
        2'h1: state_d.inWordOne[15:8] = state_q.pinStable.data;
        2'h2: state_d.inWordTwo[7:0] = state_q.pinStable.data;
        2'h3: state_d.inWordTwo[15:8] = state_q.pinStable.data;
        default: state_d.inWordOne = state_q.inWordOne;
      endcase
    end

    // software load of output words, new data beats a same-cycle take
    if (swWrite && wordAddr == `OFS_OUT_WORD_ONE) begin
      if (pstrb[0]) begin
        state_d.outWordOne[7:0] = pwdata[7:0];
        state_d.outEmpty[0] = 1'b0;
      end
      if (pstrb[1]) begin
        state_d.outWordOne[15:8] = pwdata[15:8];
        state_d.outEmpty[1] = 1'b0;
      end
    end
    if (swWrite && wordAddr == `OFS_OUT_WORD_TWO) begin
      if (pstrb[0]) begin
        state_d.outWordTwo[7:0] = pwdata[7:0];
        state_d.outEmpty[2] = 1'b0;
      end
      if (pstrb[1]) begin
        state_d.outWordTwo[15:8] = pwdata[15:8];
        state_d.outEmpty[3] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= '0;
      state_q.sync1 <= '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, addr: 2'h0, data: 8'h00};
      state_q.sync2 <= '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, addr: 2'h0, data: 8'h00};
      state_q.sync3 <= '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, addr: 2'h0, data: 8'h00};
      state_q.pinStable <= '{csN: 1'b1, rdN: 1'b1, wrN: 1'b1, addr: 2'h0, data: 8'h00};
      state_q.outEmpty <= `RST_OUT_EMPTY;
      state_q.inFull <= `RST_IN_FULL;
      state_q.padConfig <= `RST_PAD_CONFIG;
      state_q.irqMask <= `RST_IRQ_MASK;
    end else begin
      state_q <= state_d;
    end
  end

  assign prdata = state_q.rdata;
  assign pready = 1'b1;
  assign pslverr = apbAccess && !mapped;
  assign hostDataOut = state_q.hostDataOut;
  assign hostDataOe = !state_q.pinStable.csN && !state_q.pinStable.rdN && !state_q.masterMode;
  assign masterAddress = state_q.outWordOne;
  assign masterMode = state_q.masterMode;
  assign portInputThresholdSelect = state_q.padConfig[`BIT_THRESHOLD];
  assign calendarPinOe = calendarPinOutputEnable;
  assign calendarPin = calendarPinOutputEnable &&
                       (state_q.padConfig[`BIT_SOURCE_SELECT] ? secondsClock : alarmPulse);
  assign irq = |(state_q.irqStatus & state_q.irqMask);

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  chk_byte_select: assert property (
    hostRead |=> hostDataOut == $past(selByte))
    else $error("host read returned wrong byte");
  chk_empty_summary: assert property (
    statusWord[7] == (state_q.outEmpty == 4'hf))
    else $error("summary empty disagrees with byte flags");
  chk_underflow_set: assert property (
    hostRead && state_q.outEmpty[rdIdx] |=> state_q.outUnderflow [*2])
    else $error("underflow not raised or not sticky");
  chk_write_clears_empty: assert property (
    swWrite && paddr == `OFS_OUT_WORD_TWO && pstrb[1] |=> !state_q.outEmpty[3])
    else $error("software write left byte empty");
  chk_data_not_taken: assert property (
    !state_q.outEmpty[0] && !(hostRead && rdIdx == 2'h0) |=> !state_q.outEmpty[0])
    else $error("empty flag rose without host read");
  chk_pad_reserved: assert property (
    swRead && paddr == `OFS_PAD_CONFIG |-> prdata[31:2] == 30'h00000000)
    else $error("reserved pad bits not zero");
  chk_pin_source: assert property (
    calendarPinOutputEnable && state_q.padConfig[1] |-> calendarPin == secondsClock)
    else $error("seconds clock not on calendar pin");
  chk_pin_gated: assert property (
    !calendarPinOutputEnable |-> !calendarPin && !calendarPinOe)
    else $error("calendar pin driven while disabled");
  chk_master_addr: assert property (
    swWrite && paddr == `OFS_OUT_WORD_ONE && pstrb[1:0] == 2'h3
    |=> masterAddress == $past(pwdata[15:0]))
    else $error("master address differs from output word");
  chk_overflow_set: assert property (
    hostWrite && state_q.inFull[wrIdx] |=> state_q.inOverflow && state_q.inFull[$past(wrIdx)])
    else $error("overflow not raised on full byte");

  chk_full_on_write: assert property (
    hostWrite |=> state_q.inFull[$past(wrIdx)])
    else $error("input byte not marked full");
  chk_read_clears_full: assert property (
    swRead && wordAddr == `OFS_IN_WORD_ONE && !hostWrite |=> state_q.inFull[1:0] == 2'h0)
    else $error("software read left input byte full");
  chk_underflow_sticky: assert property (
    state_q.outUnderflow && !(swWrite && wordAddr == `OFS_PORT_STATUS && pstrb[0])
    |=> state_q.outUnderflow)
    else $error("underflow flag dropped without clear");
  chk_overflow_sticky: assert property (
    state_q.inOverflow && !(swWrite && wordAddr == `OFS_PORT_STATUS && pstrb[1])
    |=> state_q.inOverflow)
    else $error("overflow flag dropped without clear");
  chk_master_ignores_host: assert property (
    state_q.masterMode && !swWrite |=> $stable(state_q.outEmpty) && !hostDataOe)
    else $error("host strobe acted in master mode");
  chk_pad_write: assert property (
    swWrite && wordAddr == `OFS_PAD_CONFIG && pstrb[0]
    |=> state_q.padConfig == $past(pwdata[1:0]))
    else $error("pad config write lost");
  chk_status_reserved: assert property (
    swRead && wordAddr == `OFS_PORT_STATUS
    |-> prdata[31:16] == 16'h0000 && prdata[13:12] == 2'h0 && prdata[5:4] == 2'h0)
    else $error("reserved status bits not zero");

  cov_host_read: cover property (hostRead ##[1:20] hostRead);
  cov_host_write: cover property (hostWrite);
  cov_underflow: cover property ($rose(state_q.outUnderflow));
  cov_irq: cover property ($rose(irq));
  cov_overflow: cover property ($rose(state_q.inOverflow));

endmodule

// file: testbench/host_model.sv
`timescale 1ns/1ns
module host_model (
  input wire logic sys_clk,
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOe,
  output logic hostCsN,
  output logic hostRdN,
  output logic hostWrN,
  output logic [1:0] portAddressLines,
  output logic [7:0] hostDataIn
);
  logic oeSeen;
  initial begin
    oeSeen = 1'b0;
    hostCsN = 1'b1;
    hostRdN = 1'b1;
    hostWrN = 1'b1;
    portAddressLines = 2'h0;
    hostDataIn = 8'h00;
  end
  // one byte cycle, strobe of eight clocks, gaps of three clocks or more
  task automatic access(input logic w, input logic [1:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge sys_clk);
    hostCsN <= 1'b0;
    portAddressLines <= a;
    hostDataIn <= d;
    repeat (3) @(posedge sys_clk);
    hostRdN <= w;
    hostWrN <= !w;
    repeat (8) @(posedge sys_clk);
    q = hostDataOut;
    oeSeen = hostDataOe;
    hostRdN <= 1'b1;
    hostWrN <= 1'b1;
    repeat (3) @(posedge sys_clk);
    hostCsN <= 1'b1;
    hostDataIn <= ~d;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule

// file: testbench/addressable_parallel_slave_buffers_tb_top.sv
`timescale 1ns/1ns
module addressable_parallel_slave_buffers_tb_top;
  logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, hostCsN, hostRdN, hostWrN;
  logic hostDataOe, masterMode, portInputThresholdSelect, secondsClock, alarmPulse;
  logic calendarPinOutputEnable, calendarPin, calendarPinOe, irq;
  logic [7:0] paddr, hostDataIn, hostDataOut;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [1:0] portAddressLines;
  logic [15:0] masterAddress;
  int failures, samples_checked;

  parallel_slave_port dut (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hostCsN(hostCsN), .hostRdN(hostRdN), .hostWrN(hostWrN),
    .portAddressLines(portAddressLines), .hostDataIn(hostDataIn),
    .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .masterAddress(masterAddress),
    .masterMode(masterMode), .portInputThresholdSelect(portInputThresholdSelect),
    .secondsClock(secondsClock), .alarmPulse(alarmPulse),
    .calendarPinOutputEnable(calendarPinOutputEnable), .calendarPin(calendarPin),
    .calendarPinOe(calendarPinOe), .irq(irq)
  );
  host_model host (
    .sys_clk(sys_clk), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
    .hostCsN(hostCsN), .hostRdN(hostRdN), .hostWrN(hostWrN),
    .portAddressLines(portAddressLines), .hostDataIn(hostDataIn)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      $display("mismatch pready expected 1 seen %b", pready);
      results();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic s;
    apb(1'b0, a, 32'h0, q, s);
    check(n, e, q);
  endtask

  task automatic testReset;
    rd("status", 8'h10, 32'h8f);
    rd("pad config", 8'h14, 32'h0);
    check("irq", 32'h0, {31'h0, irq});
    $display("test reset done");
  endtask

  task automatic testOutput;
    logic [7:0] q;
    logic [7:0] b [4] = '{8'h34, 8'h12, 8'hef, 8'hbe};
    wr(8'h00, 32'h1234);
    wr(8'h04, 32'hbeef);
    rd("status full", 8'h10, 32'h0);
    check("master address", 32'h1234, {16'h0, masterAddress});
    for (int i = 0; i < 4; i++) begin
      host.access(1'b0, 2'(i), 8'h00, q);
      check("host byte", {24'h0, b[i]}, {24'h0, q});
      check("host oe", 32'h1, {31'h0, host.oeSeen});
      rd("status taken", 8'h10, (i == 3) ? 32'h8f : 32'((2 << i) - 1));
    end
    host.access(1'b0, 2'h2, 8'h00, q);
    rd("underflow", 8'h10, 32'hcf);
    wr(8'h10, 32'h40);
    rd("underflow cleared", 8'h10, 32'h8f);
    $display("test output done");
  endtask

  task automatic testInput;
    logic [7:0] q;
    host.access(1'b1, 2'h2, 8'ha5, q);
    host.access(1'b1, 2'h3, 8'h5a, q);
    rd("input full", 8'h10, 32'h0c8f);
    rd("input word two", 8'h0c, 32'h5aa5);
    rd("input read", 8'h10, 32'h8f);
    host.access(1'b1, 2'h0, 8'h11, q);
    host.access(1'b1, 2'h0, 8'h22, q);
    rd("overflow", 8'h10, 32'h418f);
    rd("input word one", 8'h08, 32'h22);
    wr(8'h10, 32'h4000);
    rd("overflow cleared", 8'h10, 32'h8f);
    rd("irq status", 8'h1c, 32'hf);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(8'h20, 32'h4);
    @(negedge sys_clk);
    check("irq raised", 32'h1, {31'h0, irq});
    wr(8'h1c, 32'h4);
    @(negedge sys_clk);
    check("irq cleared", 32'h0, {31'h0, irq});
    rd("irq status left", 8'h1c, 32'hb);
    $display("test input done");
  endtask

  task automatic testPad;
    logic [31:0] q;
    logic e;
    wr(8'h14, 32'hffff);
    rd("pad config", 8'h14, 32'h3);
    check("threshold", 32'h1, {31'h0, portInputThresholdSelect});
    @(posedge sys_clk);
    secondsClock <= 1'b1;
    calendarPinOutputEnable <= 1'b1;
    @(negedge sys_clk);
    check("pin seconds", 32'h1, {31'h0, calendarPin});
    wr(8'h14, 32'h0);
    @(negedge sys_clk);
    check("pin alarm low", 32'h0, {31'h0, calendarPin});
    @(posedge sys_clk);
    alarmPulse <= 1'b1;
    @(negedge sys_clk);
    check("pin alarm high", 32'h1, {31'h0, calendarPin});
    @(posedge sys_clk);
    calendarPinOutputEnable <= 1'b0;
    @(negedge sys_clk);
    check("pin disabled", 32'h0, {30'h0, calendarPin, calendarPinOe});
    apb(1'b0, 8'h30, 32'h0, q, e);
    check("unmapped error", 32'h1, {31'h0, e});
    $display("test pad done");
  endtask

  task automatic testMaster;
    logic [7:0] q;
    wr(8'h18, 32'h1);
    @(negedge sys_clk);
    check("master mode", 32'h1, {31'h0, masterMode});
    rd("control", 8'h18, 32'h1);
    host.access(1'b0, 2'h0, 8'h00, q);
    check("master oe", 32'h0, {31'h0, host.oeSeen});
    host.access(1'b1, 2'h1, 8'h77, q);
    rd("master status", 8'h10, 32'h8f);
    rd("master irq", 8'h1c, 32'hb);
    wr(8'h18, 32'h0);
    @(negedge sys_clk);
    check("slave mode", 32'h0, {31'h0, masterMode});
    $display("test master done");
  endtask

  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    $display("watchdog expired");
    results();
  end

  initial begin
    {nrst, psel, penable, pwrite, secondsClock, alarmPulse, calendarPinOutputEnable} = 7'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    testReset();
    testOutput();
    testInput();
    testPad();
    testMaster();
    results();
  end
endmodule
